//--- common/trig_load_pkg.sv
// Package holding constants, register map and enumerations of the trigger and block load block
// ============================================================
package trig_load_pkg;
    // ============================================================
    // Register map (byte addresses, word aligned)
    localparam logic [5:0] CTRL_OFS   = 6'h00;
    localparam logic [5:0] COUNT_OFS  = 6'h04;
    localparam logic [5:0] TIMER_OFS  = 6'h08;
    localparam logic [5:0] SIZE_OFS   = 6'h0C;
    localparam logic [5:0] START_OFS  = 6'h10;
    localparam logic [5:0] STOP_OFS   = 6'h14;
    localparam logic [5:0] CMD_OFS    = 6'h18;
    localparam logic [5:0] STATUS_OFS = 6'h1C;
    localparam logic [5:0] SMBASE_OFS = 6'h20;
    // Control fields
    localparam int SRC_LSB = 0;      // 4-bit start source
    localparam int ADV_LSB = 4;      // 2-bit advance source
    localparam int POL_BIT = 8;
    localparam int GATE_BIT = 9;
    localparam int SEQ_BIT = 10;
    localparam int CONT_BIT = 11;
    // Command fields
    localparam int CMD_IMM = 0;
    localparam int CMD_BUS = 1;
    localparam int CMD_DEF = 2;
    localparam int CMD_LIM = 3;
    localparam int CMD_SHARED_MEMORY_SOURCE = 4;
    // Source codes
    localparam logic [3:0] SRC_FRONT = 4'h0;
    localparam logic [3:0] SRC_TIMER = 4'h1;
    localparam logic [3:0] SRC_CHAIN = 4'h2;
    localparam logic [3:0] SRC_ECHAIN = 4'h3;
    localparam logic [3:0] SRC_TTL0  = 4'h8;
    // Limits and defaults
    localparam logic [19:0] COUNT_MAX_FIXED = 20'hFFFFF;
    localparam logic [19:0] COUNT_MAX_SEQ   = 20'h10000;
    localparam logic [19:0] COUNT_RST       = 20'h00001;
    localparam logic [3:0]  SRC_RST         = SRC_TIMER;
    localparam int          WIN_GAP         = 8;
    localparam int          ADDR_W          = 17;
    localparam int          SAMPLE_W        = 12;
    localparam logic [7:0]  BLOCK_HASH      = 8'h23;
    localparam logic [7:0]  ASCII_ZERO      = 8'h30;
    // Timer: 2e-7 s steps, ticks at 125 MHz
    localparam real CLK_NS     = 8.0;
    localparam real TSTEP_NS   = 200.0;
    localparam int  TSTEP_CYC  = int'(TSTEP_NS / CLK_NS);
    localparam logic [35:0] TIMER_RST = 36'h000001388; // 1e-3 s in steps
    localparam logic [35:0] TIMER_MAX = 36'h0BA43B740; // 625 s in steps
    // Block parser states
    typedef enum logic [5:0] {
        BP_IDLE = 6'b000001,
        BP_NDIG = 6'b000010,
        BP_CNT  = 6'b000100,
        BP_HI   = 6'b001000,
        BP_LO   = 6'b010000,
        BP_SHARED_MEMORY_SOURCE = 6'b100000
    } bp_state_t;
endpackage

//--- verilog/edge_sync.sv
// Two-flop synchroniser with polarity and rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    input  wire logic invert_i,
    output logic      level_o,
    output logic      pulse_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    // ============================================================
    // Only sync_reg reads the first stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b1; // Blocks a false edge when negative polarity is set
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            prev_reg <= level_o;
        end
    end
    assign level_o = sync_reg ^ invert_i;
    assign pulse_o = level_o & ~prev_reg;
endmodule // edge_sync
`default_nettype wire

//--- verilog/trig_load.sv
// Trigger control and binary block load engine
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
module trig_load
    import trig_load_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Avalon-MM slave
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    // Trigger pins
    input  wire logic                front_trigger_input_i,
    input  wire logic                chain_left_i,
    input  wire logic                chain_end_i,
    input  wire logic [7:0]          ttl_trig_i,
    // Playback engine
    input  wire logic                pass_done_i,
    output logic                     play_o,
    output logic                     advance_o,
    output logic                     trig_pulse_o,
    // Host byte stream
    input  wire logic                host_valid_i,
    input  wire logic [7:0]          host_data_i,
    output logic                     host_ready_o,
    output logic                     parser_valid_o,
    output logic [7:0]               parser_data_o,
    // Shared memory read port
    output logic                     shared_memory_source_rd_o,
    output logic [ADDR_W-1:0]        shared_memory_source_addr_o,
    input  wire logic                shared_memory_source_rvalid_i,
    input  wire logic [15:0]         shared_memory_source_rdata_i,
    // Trace memory write port
    output logic                     tmem_we_o,
    output logic [ADDR_W-1:0]        tmem_addr_o,
    output logic [SAMPLE_W-1:0]      tmem_data_o
);
    // ============================================================
    // Registers
    logic [31:0]       ctrl_reg;
    logic [19:0]       count_reg;
    logic [35:0]       timer_reg;
    logic [ADDR_W:0]   size_reg;
    logic [ADDR_W-1:0] start_reg, stop_reg;
    logic [ADDR_W-1:0] smbase_reg;
    logic              defined_reg;
    logic              abort_reg;
    logic              ack_reg;
    logic              win_err_reg;
    logic [ADDR_W-1:0] new_start_reg, new_stop_reg;
    logic              wr_acc, rd_acc;
    logic              cmd_imm, cmd_bus;
    logic              busy;

    // Writes land at the edge where waitrequest is sampled low
    assign wr_acc = avs_write & ack_reg;
    assign rd_acc = avs_read & ~ack_reg;
    // One wait state per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign cmd_imm = wr_acc && avs_address == CMD_OFS && avs_writedata[CMD_IMM];
    assign cmd_bus = wr_acc && avs_address == CMD_OFS && avs_writedata[CMD_BUS];

    always_ff @(posedge clk_i) begin
        if (rst_i) ack_reg <= 1'b0;
        else       ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // Byte enables honoured on the control register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 32'(SRC_RST);
        end else if (wr_acc && avs_address == CTRL_OFS) begin
            for (int b = 0; b < 4; b++)
                if (avs_byteenable[b]) ctrl_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
    end

    // Count clamped to the mode's range
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= COUNT_RST;
        end else if (wr_acc && avs_address == COUNT_OFS) begin
            if (avs_writedata[19:0] == 20'h00000)
                count_reg <= COUNT_RST;
            else if (ctrl_reg[SEQ_BIT] && avs_writedata[19:0] > COUNT_MAX_SEQ)
                count_reg <= COUNT_MAX_SEQ;
            else
                count_reg <= avs_writedata[19:0];
        end
    end

    // Timer period in 200 ns steps, 1 .. 4294967295
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_reg <= TIMER_RST;
        end else if (wr_acc && avs_address == TIMER_OFS) begin
            if (avs_writedata == 32'h00000000)
                timer_reg <= 36'h000000001;
            else
                timer_reg <= {4'h0, avs_writedata};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            size_reg <= '0;
            smbase_reg <= '0;
            new_start_reg <= '0;
            new_stop_reg <= '0;
        end else if (wr_acc) begin
            if (avs_address == SIZE_OFS)   size_reg <= avs_writedata[ADDR_W:0];
            if (avs_address == START_OFS)  new_start_reg <= avs_writedata[ADDR_W-1:0];
            if (avs_address == STOP_OFS)   new_stop_reg <= avs_writedata[ADDR_W-1:0];
            if (avs_address == SMBASE_OFS) smbase_reg <= avs_writedata[ADDR_W-1:0];
        end
    end

    // Define sets full window; limits checked before accept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            defined_reg <= 1'b0;
            start_reg <= '0;
            stop_reg <= '0;
            win_err_reg <= 1'b0;
        end else if (wr_acc && avs_address == CMD_OFS && !busy) begin
            if (avs_writedata[CMD_DEF] && size_reg > (ADDR_W+1)'(WIN_GAP)) begin
                defined_reg <= 1'b1;
                start_reg <= '0;
                stop_reg <= ADDR_W'(size_reg - 1'b1);
            end else if (avs_writedata[CMD_LIM]) begin
                if ({1'b0, new_stop_reg} > {1'b0, new_start_reg} + (ADDR_W+1)'(WIN_GAP)
                    && {1'b0, new_stop_reg} < size_reg) begin
                    start_reg <= new_start_reg;
                    stop_reg <= new_stop_reg;
                    win_err_reg <= 1'b0;
                end else begin
                    win_err_reg <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // Trigger inputs
    logic [11:0] sync_lvl, sync_pls;
    logic [11:0] raw_in;
    assign raw_in = {ttl_trig_i, chain_end_i, chain_left_i, 1'b0, front_trigger_input_i};
    for (genvar g = 0; g < 12; g++) begin : g_sync
        edge_sync u_sync (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .async_i  (raw_in[g]),
            .invert_i (ctrl_reg[POL_BIT]),
            .level_o  (sync_lvl[g]),
            .pulse_o  (sync_pls[g])
        );
    end

    // Internal periodic timer
    logic [4:0]  pre_reg;
    logic [35:0] tcnt_reg;
    logic        tick;
    assign tick = (pre_reg == 5'(TSTEP_CYC - 1)) && (tcnt_reg >= timer_reg - 1'b1);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_reg <= '0;
            tcnt_reg <= '0;
        end else if (pre_reg == 5'(TSTEP_CYC - 1)) begin
            pre_reg <= '0;
            tcnt_reg <= tick ? '0 : tcnt_reg + 1'b1;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // Source selection; timer replaces the unused pin slot
    logic [3:0] src;
    logic [1:0] adv;
    logic       src_hit, adv_hit, gated;
    assign src = ctrl_reg[SRC_LSB +: 4];
    assign adv = ctrl_reg[ADV_LSB +: 2];
    always_comb begin
        src_hit = 1'b0;
        case (src)
            SRC_FRONT:  src_hit = sync_pls[0];
            SRC_TIMER:  src_hit = tick;
            SRC_CHAIN:  src_hit = sync_pls[2];
            SRC_ECHAIN: src_hit = sync_pls[3];
            default:    src_hit = src[3] ? sync_pls[4 + src[2:0]] : 1'b0;
        endcase
    end
    always_comb begin
        adv_hit = 1'b0;
        case (adv)
            2'h0:    adv_hit = sync_pls[0];
            2'h1:    adv_hit = tick;
            2'h2:    adv_hit = sync_pls[2];
            default: adv_hit = sync_pls[3];
        endcase
    end
    assign gated = ctrl_reg[GATE_BIT] && src == SRC_FRONT;

    // ============================================================
    // Counted replay
    logic [19:0] left_reg;
    logic        run_reg;
    logic        fire;
    assign fire = src_hit | cmd_imm | cmd_bus;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_reg <= '0;
            run_reg <= 1'b0;
        end else if (!run_reg && fire && !gated) begin
            run_reg <= 1'b1;
            left_reg <= count_reg;
        end else if (run_reg && pass_done_i) begin
            if (left_reg == 20'h00001 && !ctrl_reg[CONT_BIT]) run_reg <= 1'b0;
            if (left_reg != 20'h00001) left_reg <= left_reg - 1'b1;
        end
    end
    // Later triggers fall through while running
    always_ff @(posedge clk_i) begin
        if (rst_i) trig_pulse_o <= 1'b0;
        else       trig_pulse_o <= fire & ~run_reg & ~gated;
    end
    assign play_o = gated ? sync_lvl[0] : run_reg;
    assign advance_o = run_reg & ctrl_reg[SEQ_BIT] & adv_hit;

    // ============================================================
    // Block parser
    bp_state_t         st_reg;
    logic [3:0]        ndig_reg;
    logic [23:0]       bcnt_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic [3:0]        hi_reg;
    logic [ADDR_W:0]   win_pts;
    logic              is_digit;
    assign win_pts = {1'b0, stop_reg} - {1'b0, start_reg} + 1'b1;
    assign is_digit = host_data_i >= ASCII_ZERO && host_data_i <= ASCII_ZERO + 8'h09;
    assign busy = st_reg != BP_IDLE;
    assign host_ready_o = st_reg != BP_SHARED_MEMORY_SOURCE;
    // Bytes outside a block go to the command parser
    assign parser_valid_o = host_valid_i && (st_reg == BP_IDLE) && !(host_data_i == BLOCK_HASH
                            && defined_reg);
    assign parser_data_o = host_data_i;
    assign shared_memory_source_rd_o = st_reg == BP_SHARED_MEMORY_SOURCE && !shared_memory_source_rvalid_i;
    assign shared_memory_source_addr_o = smbase_reg + ptr_reg - start_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= BP_IDLE;
            ndig_reg <= '0;
            bcnt_reg <= '0;
            ptr_reg <= '0;
            hi_reg <= '0;
            abort_reg <= 1'b0;
            tmem_we_o <= 1'b0;
            tmem_addr_o <= '0;
            tmem_data_o <= '0;
        end else begin
            tmem_we_o <= 1'b0;
            case (st_reg)
                BP_IDLE: begin
                    ptr_reg <= start_reg;
                    if (cmd_imm == 1'b0 && wr_acc && avs_address == CMD_OFS
                        && avs_writedata[CMD_SHARED_MEMORY_SOURCE] && defined_reg)
                        st_reg <= BP_SHARED_MEMORY_SOURCE;
                    else if (host_valid_i && host_data_i == BLOCK_HASH && defined_reg)
                        st_reg <= BP_NDIG;
                end
                BP_NDIG: if (host_valid_i) begin
                    ndig_reg <= host_data_i[3:0];
                    bcnt_reg <= '0;
                    if (is_digit && host_data_i != ASCII_ZERO) st_reg <= BP_CNT;
                    else begin st_reg <= BP_IDLE; abort_reg <= 1'b1; end
                end
                BP_CNT: if (host_valid_i) begin
                    bcnt_reg <= 24'(bcnt_reg * 10 + host_data_i[3:0]);
                    ndig_reg <= ndig_reg - 1'b1;
                    if (!is_digit) begin st_reg <= BP_IDLE; abort_reg <= 1'b1; end
                    else if (ndig_reg == 4'h1) begin
                        // Count must be twice the window
                        if (24'(bcnt_reg * 10 + host_data_i[3:0]) == 24'({win_pts, 1'b0})) begin
                            st_reg <= BP_HI;
                            abort_reg <= 1'b0;
                        end else begin
                            st_reg <= BP_IDLE;
                            abort_reg <= 1'b1;
                        end
                    end
                end
                BP_HI: if (host_valid_i) begin
                    hi_reg <= host_data_i[3:0];
                    st_reg <= BP_LO;
                end
                BP_LO: if (host_valid_i) begin
                    tmem_we_o <= 1'b1;
                    tmem_addr_o <= ptr_reg;
                    tmem_data_o <= {hi_reg, host_data_i};
                    ptr_reg <= ptr_reg + 1'b1;
                    st_reg <= (ptr_reg == stop_reg) ? BP_IDLE : BP_HI;
                end
                BP_SHARED_MEMORY_SOURCE: if (shared_memory_source_rvalid_i) begin
                    tmem_we_o <= 1'b1;
                    tmem_addr_o <= ptr_reg;
                    tmem_data_o <= shared_memory_source_rdata_i[SAMPLE_W-1:0];
                    ptr_reg <= ptr_reg + 1'b1;
                    if (ptr_reg == stop_reg) st_reg <= BP_IDLE;
                end
                default: st_reg <= BP_IDLE;
            endcase
        end
    end

    // ============================================================
    // Read mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_readdata <= '0;
        end else if (rd_acc) begin
            case (avs_address)
                CTRL_OFS:   avs_readdata <= ctrl_reg;
                COUNT_OFS:  avs_readdata <= {12'h000, count_reg};
                TIMER_OFS:  avs_readdata <= timer_reg[31:0];
                SIZE_OFS:   avs_readdata <= 32'(size_reg);
                START_OFS:  avs_readdata <= 32'(start_reg);
                STOP_OFS:   avs_readdata <= 32'(stop_reg);
                STATUS_OFS: avs_readdata <= {24'h000000, st_reg[0] ? 1'b0 : 1'b1,
                                             win_err_reg, abort_reg, defined_reg,
                                             gated, play_o, run_reg, busy};
                SMBASE_OFS: avs_readdata <= 32'(smbase_reg);
                default:    avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // ============================================================
    // Checks
    sequence s_fire_idle;
        fire && !run_reg && !gated;
    endsequence
    chk_fire_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fire_idle |=> run_reg && trig_pulse_o) else $error("trigger not started");
    chk_imm_trig: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_imm && !run_reg && !gated |=> run_reg) else $error("immediate lost");
    chk_busy_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        run_reg |=> !trig_pulse_o) else $error("retrigger during replay");
    chk_count_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fire_idle |=> left_reg == $past(count_reg)) else $error("count not loaded");
    chk_gate_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        gated |-> play_o == sync_lvl[0]) else $error("gate level wrong");
    chk_write_window: assert property (@(posedge clk_i) disable iff (rst_i)
        tmem_we_o |-> tmem_addr_o >= start_reg && tmem_addr_o <= stop_reg)
        else $error("write outside window");
    chk_window_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        defined_reg |-> {1'b0, stop_reg} > {1'b0, start_reg} + (ADDR_W+1)'(WIN_GAP))
        else $error("window too small");
    chk_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(abort_reg) |-> st_reg == BP_IDLE) else $error("abort not idle");
    chk_count_range: assert property (@(posedge clk_i) disable iff (rst_i)
        count_reg != 20'h00000) else $error("zero count");
endmodule // trig_load
`default_nettype wire

//--- test/host_model.sv
// Remote host model that streams length-prefixed binary blocks
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    output logic            valid_o,
    output logic [7:0]      data_o
);
    // ============================================================
    // Byte sender: a byte stands until an edge samples ready high
    initial begin
        valid_o = 1'b0;
        data_o  = 8'h00;
    end
    task automatic put(input logic [7:0] b);
        valid_o <= 1'b1;
        data_o  <= b;
        do @(posedge clk_i); while (ready_i !== 1'b1);
    endtask
    // Header, two-digit count, then points high byte first
    task automatic block(input int n, input int cnt, input logic [11:0] v0);
        logic [11:0] v;
        @(posedge clk_i);
        put(8'h23);
        put(8'h32);
        put(8'h30 + 8'(cnt / 10));
        put(8'h30 + 8'(cnt % 10));
        for (int i = 0; i < n; i++) begin
            v = v0 + 12'(i);
            put({4'h0, v[11:8]});
            put(v[7:0]);
        end
        // Released line shows no stale byte
        valid_o <= 1'b0;
        data_o  <= ~v[7:0];
    endtask
endmodule // host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for trigger control and block load
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import trig_load_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, avs_read = 1'b0, avs_write = 1'b0, done_i = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic wait_o, play_o, trig_o, hvalid, hready, pvalid, shared_memory_source_rd, srv = 1'b0, tmem_we;
    logic adv_o, adv_seen = 1'b0;
    logic [10:0] pins = 11'h000;
    logic [7:0] hdata, pdata, plast = 8'h00;
    logic [ADDR_W-1:0] saddr, taddr;
    logic [15:0] sdata = 16'h0000;
    logic [SAMPLE_W-1:0] tdata;
    logic [SAMPLE_W-1:0] mem [0:31];
    int error_cnt = 0, comparisons = 0, n;
    trig_load u_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(wait_o),
        .front_trigger_input_i(pins[0]), .chain_left_i(pins[1]), .chain_end_i(pins[2]),
        .ttl_trig_i(pins[10:3]), .pass_done_i(done_i), .play_o(play_o), .advance_o(adv_o),
        .trig_pulse_o(trig_o), .host_valid_i(hvalid), .host_data_i(hdata),
        .host_ready_o(hready), .parser_valid_o(pvalid), .parser_data_o(pdata),
        .shared_memory_source_rd_o(shared_memory_source_rd), .shared_memory_source_addr_o(saddr), .shared_memory_source_rvalid_i(srv),
        .shared_memory_source_rdata_i(sdata), .tmem_we_o(tmem_we), .tmem_addr_o(taddr), .tmem_data_o(tdata));
    host_model u_host (.clk_i(clk_i), .ready_i(hready), .valid_o(hvalid), .data_o(hdata));
    // ============================================================
    // Clock, trace memory capture, parser tap, shared memory responder
    initial forever #4 clk_i = ~clk_i;
    initial foreach (mem[i]) mem[i] = 12'h000;
    always @(posedge clk_i) begin
        if (tmem_we === 1'b1 && taddr < 32) mem[taddr[4:0]] <= tdata;
        if (pvalid === 1'b1) plast <= pdata;
        if (adv_o === 1'b1) adv_seen <= 1'b1;
        srv <= shared_memory_source_rd && !srv; // One word per request, stale data inverted
        sdata <= (shared_memory_source_rd && !srv) ? {4'h0, saddr[11:0] ^ 12'h5A5} : ~sdata;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Avalon access: hold until waitrequest is sampled low, take data there
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_i);
            k++;
        end while (wait_o !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 20) error_cnt++;
    endtask
    // Cycles until a trigger pulse, m if none came
    task automatic wt(input int m);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (trig_o !== 1'b1 && n < m);
    endtask
    // End of one trace pass from the playback engine
    task automatic fin();
        @(posedge clk_i) done_i <= 1'b1;
        @(posedge clk_i) done_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog sized well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, CTRL_OFS, 0); chk(rd[3:0], SRC_TIMER);
        acc(0, COUNT_OFS, 0); chk(rd, 32'h1);
        acc(0, TIMER_OFS, 0); chk(rd, 32'h1388);
        acc(0, 6'h3C, 0); chk(rd, 32'h0);
        $display("reset values done");
        // Every pin start source fires; a neighbouring pin must not
        for (int s = 0; s < 11; s++) begin
            acc(1, CTRL_OFS, 32'((s == 0) ? 0 : (s < 3) ? s + 1 : s + 5));
            pins[(s + 1) % 11] <= 1'b1;
            wt(6); chk(n, 6);
            pins[(s + 1) % 11] <= 1'b0;
            pins[s] <= 1'b1;
            wt(8); chk(32'(n < 8), 1);
            pins[s] <= 1'b0;
            fin();
        end
        $display("source select done");
        // Immediate and bus triggers, counted replay of two passes; the front pin edge is not the selected TTL7 source
        acc(1, COUNT_OFS, 2);
        for (int c = CMD_IMM; c <= CMD_BUS; c++) begin
            acc(1, CMD_OFS, 32'h1 << c); @(posedge clk_i); chk(play_o, 1);
            pins[0] <= 1'b1;
            wt(6); chk(n, 6);
            pins[0] <= 1'b0;
            fin(); chk(play_o, 1);
            fin(); chk(play_o, 0);
        end
        acc(1, COUNT_OFS, 1);
        // Sequence mode: front edge advances while running from an immediate start, TTL0 source
        acc(1, CTRL_OFS, 32'h8 | (32'h1 << SEQ_BIT));
        acc(1, CMD_OFS, 32'h1 << CMD_IMM);
        pins[0] <= 1'b1;
        repeat (6) @(posedge clk_i); chk(adv_seen, 1);
        pins[0] <= 1'b0;
        fin();
        // Negative polarity: the falling pin edge is the active one
        pins[0] <= 1'b1;
        acc(1, CTRL_OFS, 32'h1 << POL_BIT);
        pins[0] <= 1'b0;
        wt(8); chk(32'(n < 8), 1);
        fin();
        // Gated output follows the front level
        acc(1, CTRL_OFS, 32'h1 << GATE_BIT);
        pins[0] <= 1'b1;
        repeat (6) @(posedge clk_i); chk(play_o, 1);
        pins[0] <= 1'b0;
        repeat (6) @(posedge clk_i); chk(play_o, 0);
        // Timer of two steps gives a 50-cycle trigger period
        acc(1, TIMER_OFS, 2);
        acc(1, CTRL_OFS, 32'(SRC_TIMER));
        wt(60); fin(); wt(60); chk(32'(n > 44 && n < 50), 1);
        acc(1, CTRL_OFS, 0);
        fin();
        $display("trigger modes done");
        // Define, refused then accepted window, block download
        acc(1, SIZE_OFS, 16); acc(1, CMD_OFS, 32'h1 << CMD_DEF);
        acc(1, START_OFS, 4); acc(1, STOP_OFS, 12); acc(1, CMD_OFS, 32'h1 << CMD_LIM);
        acc(0, STATUS_OFS, 0); chk(rd[6], 1);
        acc(1, STOP_OFS, 13); acc(1, CMD_OFS, 32'h1 << CMD_LIM);
        u_host.block(10, 20, 12'hA40);
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 10; i++) chk(mem[4 + i], 12'hA40 + 12'(i));
        chk(mem[3], 0); chk(mem[14], 0);
        // Short count aborts; trailing bytes reach the command parser
        u_host.block(1, 8, 12'h055);
        repeat (4) @(posedge clk_i);
        acc(0, STATUS_OFS, 0); chk(rd[5], 1);
        chk(plast, 8'h55); chk(mem[4], 12'hA40);
        $display("block load done");
        // Shared memory copy from the base into the window
        acc(1, SMBASE_OFS, 32'h100); acc(1, CMD_OFS, 32'h1 << CMD_SHARED_MEMORY_SOURCE);
        n = 0;
        do begin
            acc(0, STATUS_OFS, 0);
            n++;
        end while (rd[0] !== 1'b0 && n < 30);
        for (int i = 0; i < 10; i++) chk(mem[4 + i], (12'h100 + 12'(i)) ^ 12'h5A5);
        $display("shared memory load done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
